// ---- pkg/cmpm_pkg.sv ----
package cmpm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map, io address space
    localparam int IO_AW = 6;
    localparam logic [5:0] CMP_VALUE_OFS = 6'h23;
    localparam logic [5:0] FLAGS_OFS = 6'h36;
    localparam logic [5:0] MASK_OFS = 6'h37;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CMP_BIT = 7;
    localparam int OVF_BIT = 6;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] CMP_VALUE_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // compare output mode field value that leaves the pin to the port
    localparam logic [1:0] COM_OFF = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } cmpm_io_req_t;

    typedef struct packed {
        logic [1:0] wide_mode;
        logic [1:0] carrier_mode;
        logic wide_wave;
        logic carrier_wave;
        logic latch;
        logic direction;
    } cmpm_pin_ctl_t;

    typedef enum {
        SRC_PORT,
        SRC_WIDE,
        SRC_CARRIER,
        SRC_AND,
        SRC_OR
    } cmpm_pin_src_t;

endpackage

// ---- core/cmpm_sync3.sv ----
module cmpm_sync3 (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic async_in,
    output logic sync_out
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;
    logic out_d;

    ////////////////////////////////////////////////////////////////////////////
    // accept a change only once the two later stages agree
    always_comb begin
        out_d = out_q;
        if (s2_q == s3_q) begin
            out_d = s3_q;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;

endmodule // cmpm_sync3

// ---- core/cmpm_top.sv ----
// Behaviour
// - hold 8-bit compare value, compare with counter every timer tick.
// - compare irq needs mask bit 7, global enable and compare flag.
// - overflow irq needs mask bit 6, global enable and overflow flag.
// - flag bit 7 sets when counter equals compare value.
// - flag bit 6 sets when the 8-bit counter overflows.
// - in pwm modes overflow flag sets on direction reversal at bottom.
// - each flag clears when its interrupt handler is entered.
// - writing one clears a flag, writing zero leaves it.
// - modulator inputs are wide timer unit c and carrier compare outputs.
// - modulator disabled while the legacy compatibility fuse is set.
// - a nonzero mode field lets that compare output replace the latch.
// - modulator turns on by itself when both outputs are enabled.
// - while modulating, latch low selects and, latch high selects or.
// - direction bit alone controls the pin output driver.
// - modulated resolution drops by carrier period in system clocks.
module cmpm_top (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input cmpm_pkg::cmpm_io_req_t io_req_in,
    output logic [7:0] io_rdata_out,
    input wire logic [7:0] counter_value_in,
    input wire logic timer_tick_in,
    input wire logic counter_overflow_in,
    input wire logic bottom_reverse_in,
    input wire logic pwm_mode_in,
    input wire logic global_irq_enable_in,
    input wire logic compare_irq_ack_in,
    input wire logic overflow_irq_ack_in,
    input cmpm_pkg::cmpm_pin_ctl_t pin_ctl_in,
    input wire logic compat_fuse_in,
    output logic compare_match_out,
    output logic compare_irq_out,
    output logic overflow_irq_out,
    output logic shared_output_pin_out,
    output logic shared_output_pin_oe_out
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0] compare_value_q;
    logic [7:0] compare_value_d;
    logic [1:0] irq_enable_q;
    logic [1:0] irq_enable_d;
    logic compare_match_flag_q;
    logic compare_match_flag_d;
    logic overflow_flag_q;
    logic overflow_flag_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic match_q;
    logic match_d;
    logic cmp_irq_q;
    logic cmp_irq_d;
    logic ovf_irq_q;
    logic ovf_irq_d;
    logic pin_q;
    logic pin_d;
    logic pin_oe_q;
    logic pin_oe_d;
    logic compat_mode;
    logic cmp_set;
    logic ovf_set;
    logic cmp_clr;
    logic ovf_clr;
    logic wide_on;
    logic carrier_on;
    cmpm_pkg::cmpm_pin_src_t pin_src;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic io_write_hit(input cmpm_pkg::cmpm_io_req_t req,
                                          input logic [5:0] ofs);
        io_write_hit = req.we && (req.addr == ofs);
    endfunction

    function automatic logic io_read_hit(input cmpm_pkg::cmpm_io_req_t req,
                                         input logic [5:0] ofs);
        io_read_hit = req.re && (req.addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // fuse level comes from outside the clock domain
    cmpm_sync3 u_fuse_sync (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .async_in(compat_fuse_in),
        .sync_out(compat_mode)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    always_comb begin
        compare_value_d = compare_value_q;
        irq_enable_d = irq_enable_q;
        if (io_write_hit(io_req_in, cmpm_pkg::CMP_VALUE_OFS)) begin
            compare_value_d = io_req_in.wdata;
        end
        if (io_write_hit(io_req_in, cmpm_pkg::MASK_OFS)) begin
            irq_enable_d = {io_req_in.wdata[cmpm_pkg::CMP_BIT],
                            io_req_in.wdata[cmpm_pkg::OVF_BIT]};
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            compare_value_q <= cmpm_pkg::CMP_VALUE_RST;
            irq_enable_q <= {cmpm_pkg::MASK_RST[cmpm_pkg::CMP_BIT],
                             cmpm_pkg::MASK_RST[cmpm_pkg::OVF_BIT]};
        end else begin
            compare_value_q <= compare_value_d;
            irq_enable_q <= irq_enable_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event flags; a set in the clearing cycle wins
    always_comb begin
        cmp_set = timer_tick_in && (counter_value_in == compare_value_q);
        match_d = cmp_set;
        // pwm modes raise overflow at the bottom turn instead of the wrap
        ovf_set = pwm_mode_in ? bottom_reverse_in : counter_overflow_in;
        cmp_clr = compare_irq_ack_in;
        ovf_clr = overflow_irq_ack_in;
        if (io_write_hit(io_req_in, cmpm_pkg::FLAGS_OFS)) begin
            cmp_clr = cmp_clr || io_req_in.wdata[cmpm_pkg::CMP_BIT];
            ovf_clr = ovf_clr || io_req_in.wdata[cmpm_pkg::OVF_BIT];
        end
        compare_match_flag_d = cmp_set || (compare_match_flag_q && !cmp_clr);
        overflow_flag_d = ovf_set || (overflow_flag_q && !ovf_clr);
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            compare_match_flag_q <= cmpm_pkg::FLAGS_RST[cmpm_pkg::CMP_BIT];
            overflow_flag_q <= cmpm_pkg::FLAGS_RST[cmpm_pkg::OVF_BIT];
            match_q <= 1'b0;
        end else begin
            compare_match_flag_q <= compare_match_flag_d;
            overflow_flag_q <= overflow_flag_d;
            match_q <= match_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt requests, one cycle behind the flags
    always_comb begin
        cmp_irq_d = irq_enable_q[1] && global_irq_enable_in && compare_match_flag_q;
        ovf_irq_d = irq_enable_q[0] && global_irq_enable_in && overflow_flag_q;
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmp_irq_q <= 1'b0;
            ovf_irq_q <= 1'b0;
        end else begin
            cmp_irq_q <= cmp_irq_d;
            ovf_irq_q <= ovf_irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered; unmapped offsets read zero
    always_comb begin
        rdata_d = rdata_q;
        if (io_read_hit(io_req_in, cmpm_pkg::CMP_VALUE_OFS)) begin
            rdata_d = compare_value_q;
        end else if (io_read_hit(io_req_in, cmpm_pkg::FLAGS_OFS)) begin
            rdata_d = {compare_match_flag_q, overflow_flag_q, 6'h00};
        end else if (io_read_hit(io_req_in, cmpm_pkg::MASK_OFS)) begin
            rdata_d = {irq_enable_q, 6'h00};
        end else if (io_req_in.re) begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= cmpm_pkg::RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared pin modulator
    always_comb begin
        wide_on = pin_ctl_in.wide_mode != cmpm_pkg::COM_OFF;
        carrier_on = pin_ctl_in.carrier_mode != cmpm_pkg::COM_OFF;
        pin_src = cmpm_pkg::SRC_PORT;
        if (wide_on && carrier_on && !compat_mode) begin
            // no enable bit: both outputs on means modulate
            pin_src = pin_ctl_in.latch ? cmpm_pkg::SRC_OR : cmpm_pkg::SRC_AND;
        end else if (wide_on) begin
            // legacy mode with both on: wide unit keeps the pin
            pin_src = cmpm_pkg::SRC_WIDE;
        end else if (carrier_on) begin
            pin_src = cmpm_pkg::SRC_CARRIER;
        end
    end

    always_comb begin
        // sampled per system clock, so a pwm edge inside a carrier period is lost
        case (pin_src)
            cmpm_pkg::SRC_PORT: pin_d = pin_ctl_in.latch;
            cmpm_pkg::SRC_WIDE: pin_d = pin_ctl_in.wide_wave;
            cmpm_pkg::SRC_CARRIER: pin_d = pin_ctl_in.carrier_wave;
            cmpm_pkg::SRC_AND: pin_d = pin_ctl_in.wide_wave && pin_ctl_in.carrier_wave;
            cmpm_pkg::SRC_OR: pin_d = pin_ctl_in.wide_wave || pin_ctl_in.carrier_wave;
            default: pin_d = pin_ctl_in.latch;
        endcase
        pin_oe_d = pin_ctl_in.direction;
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign io_rdata_out = rdata_q;
    assign compare_match_out = match_q;
    assign compare_irq_out = cmp_irq_q;
    assign overflow_irq_out = ovf_irq_q;
    assign shared_output_pin_out = pin_q;
    assign shared_output_pin_oe_out = pin_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_flags_write;
        io_req_in.we && io_req_in.addr == cmpm_pkg::FLAGS_OFS;
    endsequence

    sequence s_both_on;
        pin_ctl_in.wide_mode != 2'h0 && pin_ctl_in.carrier_mode != 2'h0 && !compat_mode;
    endsequence

    property p_cmp_value_store;
        io_req_in.we && io_req_in.addr == cmpm_pkg::CMP_VALUE_OFS
            |=> compare_value_q == $past(io_req_in.wdata);
    endproperty
    a_cmp_value_store: assert property (p_cmp_value_store)
        else $error("compare value not stored");

    property p_cmp_set;
        timer_tick_in && counter_value_in == compare_value_q
            |=> compare_match_flag_q && compare_match_out;
    endproperty
    a_cmp_set: assert property (p_cmp_set)
        else $error("compare flag missed a match");

    property p_ovf_source;
        (pwm_mode_in ? bottom_reverse_in : counter_overflow_in) |=> overflow_flag_q;
    endproperty
    a_ovf_source: assert property (p_ovf_source)
        else $error("overflow flag missed its event");

    property p_ovf_no_wrap_in_pwm;
        pwm_mode_in && !bottom_reverse_in && !overflow_flag_q |=> !overflow_flag_q;
    endproperty
    a_ovf_no_wrap_in_pwm: assert property (p_ovf_no_wrap_in_pwm)
        else $error("overflow flag set without a bottom turn");

    property p_w1c;
        s_flags_write and io_req_in.wdata[7] and !cmp_set |=> !compare_match_flag_q;
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear compare flag");

    property p_w0_keep;
        s_flags_write and !io_req_in.wdata[6] and overflow_flag_q and !overflow_irq_ack_in
            |=> overflow_flag_q;
    endproperty
    a_w0_keep: assert property (p_w0_keep)
        else $error("write zero changed overflow flag");

    property p_ack_clear;
        compare_irq_ack_in && !cmp_set |=> !compare_match_flag_q;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("acknowledge did not clear compare flag");

    property p_cmp_irq;
        compare_irq_out == ($past(irq_enable_q[1]) && $past(global_irq_enable_in)
            && $past(compare_match_flag_q));
    endproperty
    a_cmp_irq: assert property (p_cmp_irq)
        else $error("compare request disagrees with enable and flag");

    property p_ovf_irq;
        overflow_irq_out |-> $past(irq_enable_q[0]) && $past(global_irq_enable_in);
    endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("overflow request without enables");

    property p_mod_and;
        s_both_on and !pin_ctl_in.latch |=> shared_output_pin_out ==
            ($past(pin_ctl_in.wide_wave) && $past(pin_ctl_in.carrier_wave));
    endproperty
    a_mod_and: assert property (p_mod_and)
        else $error("and modulation wrong");

    property p_mod_or;
        s_both_on and pin_ctl_in.latch |=> shared_output_pin_out ==
            ($past(pin_ctl_in.wide_wave) || $past(pin_ctl_in.carrier_wave));
    endproperty
    a_mod_or: assert property (p_mod_or)
        else $error("or modulation wrong");

    property p_oe;
        ##1 shared_output_pin_oe_out == $past(pin_ctl_in.direction);
    endproperty
    a_oe: assert property (p_oe)
        else $error("driver enable not following direction bit");

    property p_ovf_irq_on;
        irq_enable_q[0] && global_irq_enable_in && overflow_flag_q |=> overflow_irq_out;
    endproperty
    a_ovf_irq_on: assert property (p_ovf_irq_on)
        else $error("overflow request missing");

    property p_ovf_ack_clear;
        overflow_irq_ack_in && !ovf_set |=> !overflow_flag_q;
    endproperty
    a_ovf_ack_clear: assert property (p_ovf_ack_clear)
        else $error("acknowledge did not clear overflow flag");

    property p_cmp_hold;
        !(io_req_in.we && io_req_in.addr == cmpm_pkg::CMP_VALUE_OFS) |=> $stable(compare_value_q);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold)
        else $error("compare value changed without a write");

    // legacy fuse keeps the wide unit on the pin even with both outputs on
    property p_compat_wide;
        compat_mode && wide_on && carrier_on
            |=> shared_output_pin_out == $past(pin_ctl_in.wide_wave);
    endproperty
    a_compat_wide: assert property (p_compat_wide)
        else $error("modulator active in legacy mode");

    property p_port_latch;
        !wide_on && !carrier_on |=> shared_output_pin_out == $past(pin_ctl_in.latch);
    endproperty
    a_port_latch: assert property (p_port_latch)
        else $error("port latch not on the pin");

endmodule // cmpm_top

// ---- dv/cmpm_timer_model.sv ----
module cmpm_timer_model (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic run_in,
    input wire logic pwm_in,
    output logic [7:0] counter_out,
    output logic tick_out,
    output logic overflow_out,
    output logic reverse_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic down_q;
    ////////////////////////////////////////////////////////////////////////////
    // counter advances with its tick, so tick always qualifies a fresh value
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            counter_out <= 8'h00;
            down_q <= 1'b0;
            tick_out <= 1'b0;
            overflow_out <= 1'b0;
            reverse_out <= 1'b0;
        end else begin
            tick_out <= run_in;
            // raw top-of-count pulse in every mode; pwm must not take it as overflow
            overflow_out <= run_in && counter_out == 8'hFF;
            reverse_out <= run_in && pwm_in && down_q && counter_out == 8'h01;
            if (run_in) begin
                counter_out <= (pwm_in && down_q) ? counter_out - 8'h01 : counter_out + 8'h01;
                if (pwm_in && !down_q && counter_out == 8'hFE) begin
                    down_q <= 1'b1;
                end else if (down_q && counter_out == 8'h01) begin
                    down_q <= 1'b0;
                end
            end
        end
    end
endmodule // cmpm_timer_model

// ---- dv/testbench.sv ----
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    cmpm_pkg::cmpm_io_req_t io_req = '0;
    cmpm_pkg::cmpm_pin_ctl_t pin_ctl = '0;
    logic [7:0] rdata, cnt, rd;
    logic tick, ovf, rev, run = 1'b0, pwm = 1'b0, gie = 1'b0, cack = 1'b0, oack = 1'b0;
    logic fuse = 1'b0, match, cirq, oirq, pin, oe;
    logic [7:0] tbl [7] = '{8'h0B, 8'h49, 8'h24, 8'hD9, 8'h5D, 8'hB7, 8'h72};
    int check_count = 0;
    int bad_count = 0;
    cmpm_timer_model cmpm_timer_model_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .run_in(run), .pwm_in(pwm), .counter_out(cnt), .tick_out(tick),
        .overflow_out(ovf), .reverse_out(rev));
    cmpm_top cmpm_top_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .io_req_in(io_req),
        .io_rdata_out(rdata), .counter_value_in(cnt), .timer_tick_in(tick),
        .counter_overflow_in(ovf), .bottom_reverse_in(rev), .pwm_mode_in(pwm),
        .global_irq_enable_in(gie), .compare_irq_ack_in(cack), .overflow_irq_ack_in(oack),
        .pin_ctl_in(pin_ctl), .compat_fuse_in(fuse), .compare_match_out(match),
        .compare_irq_out(cirq), .overflow_irq_out(oirq), .shared_output_pin_out(pin),
        .shared_output_pin_oe_out(oe));
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wait_neg(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        io_req = '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(negedge ref_clk_in);
        io_req.we = 1'b0;
    endtask
    task automatic io_read(input logic [5:0] a, output logic [7:0] d);
        @(negedge ref_clk_in);
        io_req = '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(negedge ref_clk_in);
        io_req.re = 1'b0;
        d = rdata;
    endtask
    // bounded wait on a design output, counted as a mismatch when it never comes
    task automatic wait_high(ref logic s, input int lim, input string nm);
        int i;
        for (i = 0; i < lim && s !== 1'b1; i++) begin
            wait_neg(1);
        end
        `CHK(nm, 1'b1, s)
    endtask
    function automatic logic exp_pin(input cmpm_pkg::cmpm_pin_ctl_t c, input logic f);
        if (c.wide_mode != 2'h0 && c.carrier_mode != 2'h0 && !f) begin
            return c.latch ? (c.wide_wave | c.carrier_wave) : (c.wide_wave & c.carrier_wave);
        end
        if (c.wide_mode != 2'h0) return c.wide_wave;
        if (c.carrier_mode != 2'h0) return c.carrier_wave;
        return c.latch;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200us;
        bad_count++;
        finish_test();
    end
    initial begin
        wait_neg(8);
        rstn_in = 1'b1;
        io_read(cmpm_pkg::CMP_VALUE_OFS, rd); `CHK("cmp rst", 8'h00, rd)
        io_read(cmpm_pkg::FLAGS_OFS, rd); `CHK("flags rst", 8'h00, rd)
        io_read(cmpm_pkg::MASK_OFS, rd); `CHK("mask rst", 8'h00, rd)
        io_write(6'h10, 8'hFF);
        io_read(6'h10, rd); `CHK("unmapped", 8'h00, rd)
        io_write(cmpm_pkg::MASK_OFS, 8'hFF);
        io_read(cmpm_pkg::MASK_OFS, rd); `CHK("mask rw", 8'hC0, rd)
        io_write(cmpm_pkg::CMP_VALUE_OFS, 8'hA5);
        io_read(cmpm_pkg::CMP_VALUE_OFS, rd); `CHK("cmp rw", 8'hA5, rd)
        io_write(cmpm_pkg::MASK_OFS, 8'h00);
        io_write(cmpm_pkg::CMP_VALUE_OFS, 8'h05);
        // compare match, gating of its request, clearing by acknowledge
        run = 1'b1;
        wait_high(match, 300, "match");
        run = 1'b0;
        io_read(cmpm_pkg::FLAGS_OFS, rd); `CHK("cmp flag", 8'h80, rd)
        gie = 1'b1;
        wait_neg(2); `CHK("cirq unmasked", 1'b0, cirq)
        io_write(cmpm_pkg::MASK_OFS, 8'h80);
        gie = 1'b0;
        wait_neg(2); `CHK("cirq no gie", 1'b0, cirq)
        gie = 1'b1;
        wait_neg(2); `CHK("cirq on", 1'b1, cirq)
        cack = 1'b1;
        wait_neg(1);
        cack = 1'b0;
        wait_neg(2); `CHK("cirq acked", 1'b0, cirq)
        io_read(cmpm_pkg::FLAGS_OFS, rd); `CHK("cmp cleared", 8'h00, rd)
        // overflow in normal mode, then write-one clearing
        io_write(cmpm_pkg::MASK_OFS, 8'h40);
        run = 1'b1;
        wait_high(oirq, 600, "oirq");
        run = 1'b0;
        io_write(cmpm_pkg::FLAGS_OFS, 8'h00);
        io_read(cmpm_pkg::FLAGS_OFS, rd); `CHK("w0 keeps", 8'h40, rd & 8'h40)
        io_write(cmpm_pkg::FLAGS_OFS, 8'hC0);
        io_read(cmpm_pkg::FLAGS_OFS, rd); `CHK("w1 clears", 8'h00, rd)
        `CHK("oirq off", 1'b0, oirq)
        // pwm: overflow flag comes from the turn at bottom
        pwm = 1'b1;
        run = 1'b1;
        wait_high(oirq, 1000, "pwm oirq");
        run = 1'b0;
        `CHK("pwm bottom", 1'b1, cnt < 8'h08)
        gie = 1'b0;
        wait_neg(2); `CHK("oirq no gie", 1'b0, oirq)
        gie = 1'b1;
        oack = 1'b1;
        wait_neg(1);
        oack = 1'b0;
        wait_neg(2); `CHK("oirq acked", 1'b0, oirq)
        // pin source table, with and without the compatibility fuse
        for (int f = 0; f < 2; f++) begin
            fuse = f[0];
            wait_neg(6);
            for (int i = 0; i < 7; i++) begin
                pin_ctl = cmpm_pkg::cmpm_pin_ctl_t'(tbl[i]);
                wait_neg(2);
                `CHK("pin", exp_pin(pin_ctl, fuse), pin)
                `CHK("oe", pin_ctl.direction, oe)
            end
        end
        finish_test();
    end
endmodule // testbench
